// ==== shared/reset_ctrl_pkg.sv ====
// Shared constants and carriers for the reset source controller.
// Assumes a single 40 MHz system clock and an APB register master.
package reset_ctrl_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLOCK_MHZ      = 40;   // System clock rate
	localparam int PIN_PULSE_NS   = 400;  // Least reset pin low time
	localparam int PIN_PULSE_CYC  =
		(PIN_PULSE_NS * CLOCK_MHZ + 999) / 1000; // Rounded up
	localparam int OSC_SETTLE_NS  = 1000; // Extra wait, slow oscillator
	localparam int OSC_SETTLE_CYC =
		(OSC_SETTLE_NS * CLOCK_MHZ + 999) / 1000;
	localparam int DELAY_MIN_CYC  = 1;    // Shortest stretch
	localparam int DELAY_W        = 24;   // Delay counter width
	localparam int PIN_CNT_W      = 5;    // Pin filter counter width

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [11:0] STATUS_ADDR = 12'h000; // Cause flags
	localparam logic [11:0] LEVELS_ADDR = 12'h004; // Live state
	localparam int STATUS_W      = 8;
	localparam int FLAG_POWERON  = 0;
	localparam int FLAG_PIN      = 1;
	localparam int FLAG_BROWNOUT = 2;
	localparam int FLAG_WATCHDOG = 3;
	localparam int FLAG_SCAN     = 4;
	localparam int FLAG_N        = 5;     // Bits 7..5 read zero
	localparam logic [STATUS_W-1:0] STATUS_RESET = 8'h00;
	localparam logic [2:0] BROWNOUT_OFF = 3'h7; // Detector disabled
	localparam int CLOCK_SELECT_FUSE_SLOW_BIT = 3;    // Slow oscillator select

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_type;

	// Asynchronous source levels, in bit order of the sync chain
	typedef struct packed {
		logic scanResetHold; // Scan-chain reset register holds one
		logic brownoutLow;   // Detector: supply under trigger
		logic pinResetN;     // External reset pin, low active
		logic poweronLow;    // Detector: supply under threshold
	} async_src_type;

	// Idle levels: no source active, pin high. The sync chain resets
	// here so that leaving bench reset shows no false pin low.
	localparam async_src_type SRC_IDLE = '{1'b0, 1'b0, 1'b1, 1'b0};

	typedef struct packed {
		logic [2:0] brownoutLevelFuse;
		logic [1:0] startupTimeFuse;
		logic [3:0] clockSelectFuse;
	} fuse_type;

	typedef enum logic [1:0] {
		ST_RUN,     // Processor running
		ST_HOLD,    // A source is active
		ST_STRETCH  // Delay counter running
	} seq_state_type;

endpackage

// ==== hw/reset_source_controller.sv ====
// Reset source controller: merges five reset sources, stretches the
// internal reset, and records the cause in a status register on APB.
// Assumes analog detectors, pin and scan register arrive unsynchronised
// and the watchdog time-out arrives as a pulse on the system clock.
`timescale 1ns/100ps

module reset_source_controller
#(
	parameter int STARTUP_SHORT_US = 4,     // Short start-up time
	parameter int STARTUP_LONG_US  = 64000  // Long start-up time
)
(
	input  wire logic                       clock,     // 40 MHz clock
	input  wire logic                       sys_rst,   // Sync reset
	input  wire reset_ctrl_pkg::apb_req_type apbReq,   // APB request
	output      reset_ctrl_pkg::apb_rsp_type apbRsp,   // APB answer
	input  wire reset_ctrl_pkg::async_src_type srcIn,  // Async sources
	input  wire logic                       wdTimeout, // Watchdog expiry
	input  wire logic                       wdEnable,  // Watchdog on
	input  wire reset_ctrl_pkg::fuse_type   fuses,     // Fuse settings
	output      logic                       ioReset,   // Port reset
	output      logic                       cpuReset,  // Core reset
	output      logic                       vectorLoad // Fetch vector
);
	import reset_ctrl_pkg::*;

	// ------------------------------------------------------------
	// Derived counts
	// ------------------------------------------------------------
	localparam int SHORT_CYC = STARTUP_SHORT_US * CLOCK_MHZ;
	localparam int LONG_CYC  = STARTUP_LONG_US * CLOCK_MHZ;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	async_src_type         syncA;      // First stage, metastable
	async_src_type         syncB;      // Second stage
	async_src_type         syncC;      // Third stage
	async_src_type         lvl;        // Agreed source levels
	logic [PIN_CNT_W-1:0]  pinCount;   // Pin low duration
	logic                  pinLong;    // Pin low long enough
	logic                  brownoutEn; // Detector enabled by fuse
	logic                  brownoutOn; // Brownout source active
	logic                  wdPulse;    // One-cycle watchdog reset
	logic                  anySource;  // Any synced source active
	logic                  asyncSrc;   // Raw sources, for ports
	seq_state_type         state;      // Sequencer state
	seq_state_type         next_state; // Its next value
	logic [DELAY_W-1:0]    delayCount; // Stretch countdown
	logic [STATUS_W-1:0]   status;     // Cause flags
	logic [STATUS_W-1:0]   next_status;// Their next value
	logic                  apbAccess;  // Access phase, no answer yet
	logic                  apbDone;    // Transfer completes here
	logic                  statusWrite;// Status write completes

	// ------------------------------------------------------------
	// Delay selection
	// ------------------------------------------------------------
	// Start-up fuse picks the base wait; a slow oscillator on the
	// clock-select fuse adds settling time on top.
	function automatic logic [DELAY_W-1:0] delayCycles
	(
		input logic [1:0] startup_time_fuse,
		input logic [3:0] clock_select_fuse
	);
		logic [DELAY_W-1:0] base;
		base = DELAY_W'(DELAY_MIN_CYC);
		case (startup_time_fuse)
			2'h0:    base = DELAY_W'(DELAY_MIN_CYC);
			2'h1:    base = DELAY_W'(SHORT_CYC);
			default: base = DELAY_W'(LONG_CYC);
		endcase
		if (clock_select_fuse[CLOCK_SELECT_FUSE_SLOW_BIT])
		begin
			base = base + DELAY_W'(OSC_SETTLE_CYC);
		end
		// Never below one cycle
		if (base == '0)
		begin
			base = DELAY_W'(DELAY_MIN_CYC);
		end
		return base;
	endfunction

	// ------------------------------------------------------------
	// Source synchronisers
	// ------------------------------------------------------------
	// Three stages; a level counts once stages two and three agree,
	// so a single-cycle glitch at the pin is never taken.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			syncA <= SRC_IDLE;
			syncB <= SRC_IDLE;
			syncC <= SRC_IDLE;
		end
		else
		begin
			syncA <= srcIn;
			syncB <= syncA;
			syncC <= syncB;
		end
	end

	// Agreed levels per source
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			lvl <= SRC_IDLE;
		end
		else
		begin
			for (int i = 0; i < $bits(async_src_type); i++)
			begin
				if (syncB[i] == syncC[i])
				begin
					lvl[i] <= syncC[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Pin pulse filter
	// ------------------------------------------------------------
	// Counts how long the agreed pin level stays low; the flag only
	// records pulses past the least width.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			pinCount <= '0;
		end
		else if (lvl.pinResetN)
		begin
			pinCount <= '0;
		end
		else if (!pinLong)
		begin
			pinCount <= pinCount + PIN_CNT_W'(1);
		end
	end

	assign pinLong = (pinCount == PIN_CNT_W'(PIN_PULSE_CYC));

	// ------------------------------------------------------------
	// Source merging
	// ------------------------------------------------------------
	assign brownoutEn = (fuses.brownoutLevelFuse != BROWNOUT_OFF);
	assign brownoutOn = brownoutEn & lvl.brownoutLow;
	assign wdPulse    = wdTimeout & wdEnable;

	// Five sources, any one holds the core
	assign anySource = lvl.poweronLow | ~lvl.pinResetN | brownoutOn |
		lvl.scanResetHold | wdPulse;

	// Raw levels for the clockless port path
	assign asyncSrc = srcIn.poweronLow | ~srcIn.pinResetN |
		(brownoutEn & srcIn.brownoutLow) | srcIn.scanResetHold;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Hold while any source stands, then stretch by the delay count.
	// A source coming back during the stretch restarts the hold.
	always_comb
	begin
		next_state = state;
		case (state)
			ST_RUN:
			begin
				if (anySource)
				begin
					next_state = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				// Watchdog pulse lasts one cycle, so hold lasts one cycle
				// and the stretch starts on the edge after it falls
				if (!anySource)
				begin
					next_state = ST_STRETCH;
				end
			end
			ST_STRETCH:
			begin
				if (anySource)
				begin
					next_state = ST_HOLD;
				end
				else if (delayCount == DELAY_W'(DELAY_MIN_CYC))
				begin
					next_state = ST_RUN;
				end
			end
			default:
			begin
				next_state = ST_HOLD;
			end
		endcase
	end

	// State register; system reset starts a full hold
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state <= ST_HOLD;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Delay counter, loaded from the fuses on entry to stretch
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			delayCount <= DELAY_W'(DELAY_MIN_CYC);
		end
		else if (next_state == ST_STRETCH && state != ST_STRETCH)
		begin
			delayCount <= delayCycles(fuses.startupTimeFuse,
				fuses.clockSelectFuse);
		end
		else if (state == ST_STRETCH)
		begin
			delayCount <= delayCount - DELAY_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Reset outputs
	// ------------------------------------------------------------
	// Core reset is registered from the next state, so it changes on the same edge as the sequencer
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cpuReset <= 1'b1;
		end
		else
		begin
			cpuReset <= (next_state != ST_RUN);
		end
	end

	// Port reset sets straight from raw source levels, with no clock
	// needed; it lets go only with the clocked sequencer. Glitches on
	// the detectors can set it, which is the safe direction.
	always_ff @(posedge clock or posedge asyncSrc)
	begin
		if (asyncSrc)
		begin
			ioReset <= 1'b1;
		end
		else if (sys_rst)
		begin
			ioReset <= 1'b1;
		end
		else
		begin
			ioReset <= (next_state != ST_RUN);
		end
	end

	// One-cycle pulse at release: core fetches the reset vector
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			vectorLoad <= 1'b0;
		end
		else
		begin
			vectorLoad <= (state != ST_RUN) &&
				(next_state == ST_RUN);
		end
	end

	// ------------------------------------------------------------
	// Cause flags
	// ------------------------------------------------------------
	assign apbAccess   = apbReq.psel & apbReq.penable & ~apbRsp.pready;
	assign apbDone     = apbReq.psel & apbReq.penable & apbRsp.pready;
	assign statusWrite = apbDone & apbReq.pwrite &
		(apbReq.paddr == STATUS_ADDR);

	// Software zeros clear, ones keep; any hardware set on the same
	// edge wins over the clear so no cause is lost.
	always_comb
	begin
		next_status = status;
		if (statusWrite)
		begin
			next_status[FLAG_N-1:0] = status[FLAG_N-1:0] &
				apbReq.pwdata[FLAG_N-1:0];
		end
		if (lvl.poweronLow)
		begin
			// Power-on wipes the other causes
			next_status[FLAG_SCAN:FLAG_PIN] = '0;
			next_status[FLAG_POWERON] = 1'b1;
		end
		else
		begin
			if (lvl.scanResetHold)
			begin
				next_status[FLAG_SCAN] = 1'b1;
			end
			if (wdPulse)
			begin
				next_status[FLAG_WATCHDOG] = 1'b1;
			end
			if (brownoutOn)
			begin
				next_status[FLAG_BROWNOUT] = 1'b1;
			end
			if (pinLong)
			begin
				next_status[FLAG_PIN] = 1'b1;
			end
		end
		next_status[STATUS_W-1:FLAG_N] = '0;
	end

	// Flag register
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			status <= STATUS_RESET;
		end
		else
		begin
			status <= next_status;
		end
	end

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// One wait state: pready rises the cycle after penable, with
	// data and error from flops. Unmapped addresses answer pslverr.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			apbRsp <= '0;
		end
		else if (apbAccess)
		begin
			apbRsp.pready  <= 1'b1;
			apbRsp.pslverr <= 1'b0;
			apbRsp.prdata  <= '0;
			if (apbReq.paddr == STATUS_ADDR)
			begin
				// Flags as they stand; read before clearing
				apbRsp.prdata[STATUS_W-1:0] <= status;
			end
			else if (apbReq.paddr == LEVELS_ADDR)
			begin
				// Live view of sources and sequencer
				apbRsp.prdata[0] <= lvl.poweronLow;
				apbRsp.prdata[1] <= ~lvl.pinResetN;
				apbRsp.prdata[2] <= lvl.brownoutLow;
				apbRsp.prdata[3] <= lvl.scanResetHold;
				apbRsp.prdata[4] <= brownoutEn;
				apbRsp.prdata[5] <= wdEnable;
				apbRsp.prdata[6] <= (state == ST_HOLD);
				apbRsp.prdata[7] <= (state == ST_STRETCH);
			end
			else
			begin
				apbRsp.pslverr <= 1'b1;
			end
		end
		else
		begin
			// Answer stands one cycle only
			apbRsp <= '0;
		end
	end

endmodule

// ==== sim/reset_src_model.sv ====
// Far-side model: reset pin, supply detectors, scan register, watchdog.
// Assumes the bench names wanted levels; changes land after an edge.
`timescale 1ns/100ps
module reset_src_model
(
	input  wire logic                          clock,    // System clock
	input  wire reset_ctrl_pkg::async_src_type want,     // Wanted levels
	input  wire logic                          wdFire,   // Ask expiry
	output reset_ctrl_pkg::async_src_type      srcIn = 4'b0010, // Sources
	output logic                               wdTimeout = 1'b0 // Expiry
);
	import reset_ctrl_pkg::*;
	// Levels move one edge after the bench asks, never on the edge itself
	always @(posedge clock)
		srcIn <= want;
	// One expiry pulse per request, as a real watchdog gives
	always @(posedge clock)
		wdTimeout <= wdFire;
endmodule

// ==== sim/reset_ctrl_chk.sv ====
// Port checker for the reset source controller.
// Assumes fuses stay still while a reset episode runs.
`timescale 1ns/100ps
module reset_ctrl_chk
(
	input wire logic                          clock,     // System clock
	input wire logic                          sys_rst,   // Sync reset
	input wire reset_ctrl_pkg::apb_req_type   apbReq,    // APB request
	input wire reset_ctrl_pkg::apb_rsp_type   apbRsp,    // APB answer
	input wire reset_ctrl_pkg::async_src_type srcIn,     // Raw sources
	input wire logic                          wdTimeout, // Expiry
	input wire logic                          wdEnable,  // Watchdog on
	input wire reset_ctrl_pkg::fuse_type      fuses,     // Fuses
	input wire logic                          ioReset,   // Port reset
	input wire logic                          cpuReset,  // Core reset
	input wire logic                          vectorLoad // Fetch vector
);
	import reset_ctrl_pkg::*;
	logic brownOn; // Brownout counts only with the detector enabled
	logic mapped;  // Address hits a register
	assign brownOn = srcIn.brownoutLow && fuses.brownoutLevelFuse != 3'h7;
	assign mapped = apbReq.paddr == STATUS_ADDR
		|| apbReq.paddr == LEVELS_ADDR;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_access;
		apbReq.psel && apbReq.penable && !apbRsp.pready;
	endsequence
	sequence s_wd_fire;
		wdTimeout && wdEnable;
	endsequence
	a_apb_wait: assert property (s_access |=> apbRsp.pready)
		else $error("no answer after access");
	a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
		else $error("ready held too long");
	a_bad_addr: assert property (apbRsp.pready && !mapped
		|-> apbRsp.pslverr && apbRsp.prdata == 32'h0)
		else $error("unmapped access not refused");
	a_status_resv: assert property (apbRsp.pready
		&& apbReq.paddr == STATUS_ADDR |-> apbRsp.prdata[31:5] == 27'h0)
		else $error("reserved status bits set");
	a_io_async: assert property (srcIn.poweronLow || !srcIn.pinResetN
		|| srcIn.scanResetHold || brownOn |-> ioReset)
		else $error("port reset missing");
	a_wd_reset: assert property (s_wd_fire |=> cpuReset && ioReset)
		else $error("watchdog did not reset");
	a_wd_refused: assert property (wdTimeout && !wdEnable && !ioReset
		|=> !cpuReset)
		else $error("disabled watchdog reset");
	a_vector_fall: assert property (vectorLoad |-> $fell(cpuReset))
		else $error("vector load without release");
	a_fall_vector: assert property ($fell(cpuReset) |-> vectorLoad)
		else $error("release without vector load");
	a_por_hold: assert property (srcIn.poweronLow [*8] |-> cpuReset)
		else $error("power-on not held");
	a_brown_hold: assert property (brownOn [*8] |-> cpuReset)
		else $error("brownout not held");
	a_scan_hold: assert property (srcIn.scanResetHold [*8] |-> cpuReset)
		else $error("scan reset not held");
	a_pin_hold: assert property (!srcIn.pinResetN [*8] |-> cpuReset)
		else $error("pin reset not held");
endmodule
bind reset_source_controller reset_ctrl_chk u_reset_ctrl_chk
(
	.clock(clock), .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
	.srcIn(srcIn), .wdTimeout(wdTimeout), .wdEnable(wdEnable),
	.fuses(fuses), .ioReset(ioReset), .cpuReset(cpuReset),
	.vectorLoad(vectorLoad)
);

// ==== sim/tb_top.sv ====
// Self-checking bench for the reset source controller.
// Assumes the partner model drives sources; APB is spoken here.
`timescale 1ns/100ps
module tb_top;
	import reset_ctrl_pkg::*;
	logic          clock = 1'b0;     // System clock
	logic          sys_rst = 1'b1;   // Sync reset
	apb_req_type   apbReq = '0;      // APB request
	apb_rsp_type   apbRsp;           // APB answer
	async_src_type want = 4'b0010;   // Wanted sources, pin high
	async_src_type srcIn;            // Sources from the model
	logic          wdFire = 1'b0;    // Ask for an expiry
	logic          wdTimeout;        // Expiry pulse
	logic          wdEnable = 1'b0;  // Watchdog on
	fuse_type      fuses = '0;       // Shortest stretch
	logic          ioReset;          // Port reset
	logic          cpuReset;         // Core reset
	logic          vectorLoad;       // Fetch vector
	int            num_errors = 0;   // Mismatches
	int            n_tests = 0;      // Comparisons
	int            expFlags = 0;     // Model of the cause flags
	int            lens[4] = '{2, 41, 81, 81}; // Reset length per code
	logic [31:0]   rd;               // Last read data
	logic          err;              // Last error answer
	logic [31:0]   seed = 32'h136b090b; // Random state

	reset_src_model u_reset_src_model
	(
		.clock(clock), .want(want), .wdFire(wdFire), .srcIn(srcIn),
		.wdTimeout(wdTimeout)
	);
	reset_source_controller #(.STARTUP_SHORT_US(1), .STARTUP_LONG_US(2))
	u_reset_source_controller
	(
		.clock(clock), .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
		.srcIn(srcIn), .wdTimeout(wdTimeout), .wdEnable(wdEnable),
		.fuses(fuses), .ioReset(ioReset), .cpuReset(cpuReset),
		.vectorLoad(vectorLoad)
	);

	// Free-running clock
	initial
	begin
		forever #12.5 clock = ~clock;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; holds everything until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clock);
		apbReq.penable <= 1'b1;
		// Answer is taken at the same rising edge that sees pready
		do @(posedge clock); while (apbRsp.pready !== 1'b1 && ++k < 20);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
		if (k >= 20)
			num_errors++;
	endtask

	task automatic rdst();
		apb(1'b0, STATUS_ADDR, 32'h0);
		chk("status", rd, expFlags);
	endtask

	// Wait until ports are released; a release must load the vector
	task automatic wait_run(input logic fires);
		int k;
		k = 0;
		do @(negedge clock); while (ioReset !== 1'b0 && ++k < 300);
		chk("ports", {31'h0, ioReset}, 32'h0);
		chk("core", {31'h0, cpuReset}, 32'h0);
		chk("vector", {31'h0, vectorLoad}, {31'h0, fires});
	endtask

	task automatic hit(input async_src_type lv, input int n, logic fires);
		@(posedge clock);
		want <= lv;
		repeat (n) @(posedge clock);
		want <= 4'b0010;
		// Short pulses may drop the ports before the synced level
		// catches up; let the chain settle before watching release
		repeat (6) @(posedge clock);
		wait_run(fires);
	endtask

	// Expiry pulse; counts the cycles the core is held
	task automatic dog(input int len);
		int k;
		int n;
		k = 0;
		n = 0;
		@(posedge clock);
		wdFire <= 1'b1;
		@(posedge clock);
		wdFire <= 1'b0;
		while (cpuReset !== 1'b1 && k++ < 8) @(negedge clock);
		while (cpuReset === 1'b1 && n < 200)
		begin
			n++;
			@(negedge clock);
		end
		chk("held", n, len);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		wait_run(1'b1);
		rdst();
		apb(1'b1, 12'h008, 32'h1f);
		chk("err", {31'h0, err}, 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		chk("bad", {err, rd[30:0]}, 32'h80000000);
		$display("test map done");
		hit(4'b0011, 12, 1'b1);
		expFlags = 1;
		rdst();
		hit(4'b0000, 30, 1'b1);
		expFlags |= 2;
		rdst();
		hit(4'b0000, rnd() % 7 + 2, 1'b1);
		rdst();
		apb(1'b1, STATUS_ADDR, rnd() | 32'h1f);
		rdst();
		apb(1'b1, STATUS_ADDR, 32'hfe);
		expFlags &= 32'hfe;
		rdst();
		$display("test pin done");
		for (int f = 0; f < 8; f++)
		begin
			fuses.brownoutLevelFuse <= f[2:0];
			hit(4'b0110, 12, f != 7);
			if (f != 7)
				expFlags |= 4;
			rdst();
			apb(1'b1, STATUS_ADDR, 32'h0);
			expFlags = 0;
		end
		$display("test brownout done");
		dog(0);
		rdst();
		wdEnable <= 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			fuses.startupTimeFuse <= s[1:0];
			dog(lens[s]);
		end
		fuses <= '{3'h0, 2'h0, 4'h8};
		dog(42);
		expFlags = 8;
		rdst();
		$display("test watchdog done");
		fuses <= '0;
		hit(4'b1010, 12, 1'b1);
		expFlags |= 16;
		rdst();
		hit(4'b0011, 12, 1'b1);
		expFlags = 1;
		rdst();
		apb(1'b1, LEVELS_ADDR, 32'hff);
		chk("levels", {err, rd[30:0]}, 32'h30);
		$display("test scan done");
		wrap_up();
	end

	// Hang guard, far beyond the expected run
	initial
	begin
		#1000000;
		num_errors++;
		wrap_up();
	end
endmodule
